// [bench/host_parallel_access_port_bench.sv]
/* Bench joining host and device ends over the pin interface.
   Assumes one 25 MHz clock; the bench models the fetch side and write sink. */
`timescale 1ns/10ps
`default_nettype none
module host_parallel_access_port_bench;
   import hpap_pkg::*;
   logic        mclk, rstn, halfword_bus_mode, req_valid, req_ready, req_rnw, rsp_valid;
   logic        fetch_req, fetch_valid, wr_valid, wr_ready, stb;
   logic [1:0]  req_cntl, wr_cntl;
   logic [2:0]  dly;
   logic [31:0] req_wdata, rsp_rdata, fetch_data, wr_data, cur_wdata;
   logic [33:0] popq[$];
   int          n_errors, checks_done, n_fetch;
   hpap_if hpap_if_i ();
   hpap_device #(.DEPTH(FIFO_DEPTH)) hpap_device_i (.mclk(mclk), .rstn(rstn), .pins(hpap_if_i),
      .halfword_bus_mode(halfword_bus_mode), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_cntl(wr_cntl));
   hpap_host hpap_host_i (.mclk(mclk), .rstn(rstn), .pins(hpap_if_i), .halfword_bus_mode(halfword_bus_mode),
      .req_valid(req_valid), .req_ready(req_ready), .req_rnw(req_rnw), .req_cntl(req_cntl),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   hpap_checker hpap_checker_i (.mclk(mclk), .rstn(rstn), .port_chip_select_n(hpap_if_i.port_chip_select_n),
      .data_strobe_one_n(hpap_if_i.data_strobe_one_n), .data_strobe_two_n(hpap_if_i.data_strobe_two_n),
      .address_strobe_n(hpap_if_i.address_strobe_n), .access_control_field(hpap_if_i.access_control_field),
      .read_not_write(hpap_if_i.read_not_write), .host_ready_n(hpap_if_i.host_ready_n),
      .host_data_oe(hpap_if_i.host_data_oe), .dev_data_oe(hpap_if_i.dev_data_oe));
   assign stb = ~(hpap_if_i.data_strobe_one_n ^ hpap_if_i.data_strobe_two_n) | hpap_if_i.port_chip_select_n;
   always #20 mclk = ~mclk;
   // Fetch side answers four cycles late; sink records pops
   always @(posedge mclk) begin
      dly <= {dly[1:0], fetch_req & rstn};
      fetch_valid <= dly[2];
      if (fetch_req === 1'b1) begin
         fetch_data <= 32'hc0de_0000 + n_fetch;
         n_fetch++;
      end
      if (wr_valid === 1'b1 && wr_ready === 1'b1) popq.push_back({wr_cntl, wr_data});
   end
   // Wire level while the host drives a write
   always @(negedge mclk) begin
      if (rstn && stb === 1'b0 && hpap_if_i.host_data_oe === 1'b1 && !halfword_bus_mode)
         check({2'h0, hpap_if_i.port_data_bus}, {2'h0, cur_wdata});
      if (rstn && stb === 1'b0 && hpap_if_i.host_data_oe === 1'b1 && halfword_bus_mode)
         check({18'h0, hpap_if_i.port_data_bus[15:0]},
            {18'h0, hpap_if_i.halfword_select ? cur_wdata[31:16] : cur_wdata[15:0]});
   end
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One host request; optionally waits for its completion
   task automatic send(input logic rnw, input logic [1:0] cntl, input logic [31:0] d,
                       input logic wt, output logic [31:0] rd);
      int i;
      @(posedge mclk);
      cur_wdata <= d;
      req_rnw <= rnw;
      req_cntl <= cntl;
      req_wdata <= d;
      req_valid <= 1'b1;
      i = 0;
      do begin
         @(negedge mclk);
         i++;
      end while (req_ready !== 1'b1 && i < 400);
      @(posedge mclk);
      req_valid <= 1'b0;
      do begin
         @(negedge mclk);
         i++;
      end while (wt && i < 800 && (rnw ? rsp_valid : req_ready) !== 1'b1);
      if (i >= 400) n_errors++;
      rd = rsp_rdata;
   endtask
   task automatic t_write32();
      logic [31:0] rd;
      int c;
      for (c = 0; c < 4; c++) send(1'b0, 2'(c), 32'h1000_00a0 + c, 1'b1, rd);
      repeat (4) @(negedge mclk);
      check(34'(popq.size()), 34'h4);
      for (c = 0; c < 4; c++) check(popq[c], {2'(c), 32'h1000_00a0 + c});
      popq.delete();
   endtask
   task automatic t_read32();
      logic [31:0] rd;
      int c, n0;
      for (c = 2; c < 4; c++) begin
         n0 = n_fetch;
         send(1'b1, 2'(c), 32'h0, 1'b1, rd);
         check({2'h0, rd}, {2'h0, 32'hc0de_0000 + n0});
         check(34'(n_fetch - n0), 34'h1);
      end
   endtask
   task automatic t_half();
      logic [31:0] rd;
      int n0;
      @(posedge mclk);
      halfword_bus_mode <= 1'b1;
      send(1'b0, CNTL_DATA, 32'hbeef_1234, 1'b1, rd);
      repeat (4) @(negedge mclk);
      check(34'(popq.size()), 34'h1);
      check(popq[0], {CNTL_DATA, 32'hbeef_1234});
      popq.delete();
      n0 = n_fetch;
      send(1'b1, CNTL_DATA_INC, 32'h0, 1'b1, rd);
      check({2'h0, rd}, {2'h0, 32'hc0de_0000 + n0});
      check(34'(n_fetch - n0), 34'h1);
      @(posedge mclk);
      halfword_bus_mode <= 1'b0;
   endtask
   task automatic t_full();
      logic [31:0] rd;
      int i;
      wr_ready <= 1'b0;
      for (i = 0; i < 16; i++) send(1'b0, CNTL_DATA, 32'h0300_0000 + i, 1'b1, rd);
      send(1'b0, CNTL_DATA, 32'h0300_0010, 1'b0, rd);
      repeat (40) @(negedge mclk);
      check({1'b0, hpap_if_i.host_ready_n}, 34'h1);
      check(34'(popq.size()), 34'h0);
      @(posedge mclk);
      wr_ready <= 1'b1;
      repeat (120) @(negedge mclk);
      check(34'(popq.size()), 34'h11);
      for (i = 0; i < 17; i++) check(popq[i], {CNTL_DATA, 32'h0300_0000 + i});
      popq.delete();
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      conclude();
   end
   initial begin
      {mclk, rstn, halfword_bus_mode, req_valid, req_rnw, fetch_valid, dly} = '0;
      {req_cntl, req_wdata, fetch_data, cur_wdata} = '0;
      wr_ready = 1'b1;
      {n_errors, checks_done, n_fetch} = '0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      t_write32();
      t_read32();
      t_half();
      t_full();
      conclude();
   end
endmodule
`default_nettype wire

// [bench/hpap_checker.sv]
/* Checker for the strobe link between host and device ends.
   Assumes all interface signals live on the one mclk domain. */
`timescale 1ns/10ps
`default_nettype none
module hpap_checker
   import hpap_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rstn,
   input wire logic              port_chip_select_n,
   input wire logic              data_strobe_one_n,
   input wire logic              data_strobe_two_n,
   input wire logic              address_strobe_n,
   input wire logic [CNTL_W-1:0] access_control_field,
   input wire logic              read_not_write,
   input wire logic              host_ready_n,
   input wire logic              host_data_oe,
   input wire logic              dev_data_oe
);
   logic       stb;
   logic       as_q;
   logic       next_as_q;
   logic [1:0] as_cnt;
   logic [1:0] next_as_cnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Combined strobe, low when active
   assign stb = ~(data_strobe_one_n ^ data_strobe_two_n) | port_chip_select_n;
   // Counts address strobe falls in one strobe period
   always_comb begin
      next_as_q = address_strobe_n;
      next_as_cnt = stb ? 2'h0 : as_cnt + {1'b0, as_q & ~address_strobe_n};
   end
   always_ff @(posedge mclk) begin
      as_q <= rstn ? next_as_q : 1'b1;
      as_cnt <= rstn ? next_as_cnt : 2'h0;
   end
   strobe_low_a: assert property ($fell(stb) |-> !stb [*4]) else $error("strobe low too short");
   strobe_gap_a: assert property ($rose(stb) |-> stb [*4]) else $error("strobe gap too short");
   release_ready_a: assert property ($rose(stb) |-> !$past(host_ready_n)) else $error("early release");
   select_hold_a: assert property (!stb && $past(!stb) |-> $stable(access_control_field)
      && $stable(read_not_write)) else $error("selects moved");
   addr_once_a: assert property (as_cnt <= 2'h1) else $error("address strobe twice");
   ready_rise_a: assert property ($fell(stb) |-> ##[1:8] host_ready_n) else $error("no busy");
   ready_cause_a: assert property ($rose(host_ready_n) |-> !stb) else $error("busy w/o strobe");
   ready_stand_a: assert property ($fell(host_ready_n) |=> !host_ready_n [*3]) else $error("ready short");
   bus_read_a: assert property ($rose(dev_data_oe) |-> !stb && read_not_write) else $error("bad drive");
   bus_release_a: assert property (stb [*6] |-> !dev_data_oe) else $error("bus kept");
   no_contend_a: assert property (!(dev_data_oe && host_data_oe)) else $error("bus contention");
endmodule
`default_nettype wire

// [hw/hpap_device.sv]
/*
 Device end of the host parallel access port. Synchronises the host strobes,
 latches select signals, fetches read words from the DMA address generator
 and buffers write words in a 16-word FIFO.
 Assumes host pins are asynchronous to mclk and a DMA side on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module hpap_device
   import hpap_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   hpap_if.device                 pins,
   input  wire logic              halfword_bus_mode,
   output logic                   fetch_req,
   input  wire logic              fetch_valid,
   input  wire logic [DATA_W-1:0] fetch_data,
   output logic                   wr_valid,
   input  wire logic              wr_ready,
   output logic      [DATA_W-1:0] wr_data,
   output logic      [CNTL_W-1:0] wr_cntl
);
   hpap_dev_state_t    state;
   hpap_dev_state_t    next_state;
   logic [2:0]         stb_sync;
   logic [2:0]         as_sync;
   logic               stb_low;
   logic               next_stb_low;
   logic               as_low;
   logic               next_as_low;
   logic [CNTL_W-1:0]  sel_cntl;
   logic [CNTL_W-1:0]  next_sel_cntl;
   logic               sel_rnw;
   logic               next_sel_rnw;
   logic               sel_half;
   logic               next_sel_half;
   logic [DATA_W-1:0]  rd_word;
   logic [DATA_W-1:0]  next_rd_word;
   logic [HALF_W-1:0]  wr_low;
   logic [HALF_W-1:0]  next_wr_low;
   logic               ready_n;
   logic               next_ready_n;
   logic [DATA_W-1:0]  dout;
   logic [DATA_W-1:0]  next_dout;
   logic               doe;
   logic               next_doe;
   logic               fifo_in_valid;
   logic               fifo_in_ready;
   logic [DATA_W-1:0]  fifo_in_data;
   logic [DATA_W+CNTL_W-1:0] fifo_out;
   logic               stb_fall;
   logic               stb_rise;
   logic               as_fall;
   logic               is_data;
   logic               second_half;

   // Raw combined strobe into a three-stage synchroniser
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         stb_sync <= 3'h7;
         as_sync  <= 3'h7;
      end else begin
         stb_sync <= {stb_sync[1:0], hpap_strobe(pins.port_chip_select_n, pins.data_strobe_one_n,
                                                 pins.data_strobe_two_n)};
         as_sync  <= {as_sync[1:0], pins.address_strobe_n};
      end
   end

   // Debounced levels change only when stages two and three agree
   always_comb begin
      next_stb_low = stb_low;
      next_as_low  = as_low;
      if (stb_sync[2] == stb_sync[1]) begin
         next_stb_low = ~stb_sync[2];
      end
      if (as_sync[2] == as_sync[1]) begin
         next_as_low = ~as_sync[2];
      end
   end

   assign stb_fall    = next_stb_low & ~stb_low;  // One event per falling edge
   assign stb_rise    = ~next_stb_low & stb_low;
   assign as_fall     = next_as_low & ~as_low;
   assign is_data     = (sel_cntl == CNTL_DATA) || (sel_cntl == CNTL_DATA_INC);
   assign second_half = halfword_bus_mode & sel_half;

   // Write FIFO towards the DMA side
   assign fifo_in_data = second_half ? {pins.port_data_bus[HALF_W-1:0], wr_low} : pins.port_data_bus;
   hpap_fifo #(
      .WIDTH (DATA_W + CNTL_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rstn      (rstn),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   ({sel_cntl, fifo_in_data}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (fifo_out)
   );
   assign wr_data = fifo_out[DATA_W-1:0];
   assign wr_cntl = fifo_out[DATA_W+CNTL_W-1:DATA_W];

   // Access sequencing
   always_comb begin
      next_state    = state;
      next_sel_cntl = sel_cntl;
      next_sel_rnw  = sel_rnw;
      next_sel_half = sel_half;
      next_rd_word  = rd_word;
      next_wr_low   = wr_low;
      next_ready_n  = ready_n;
      next_dout     = dout;
      next_doe      = doe;
      fetch_req     = 1'b0;
      fifo_in_valid = 1'b0;
      // Latch selects on address strobe fall, or on strobe fall when it is unused
      if (as_fall || (stb_fall && !as_low)) begin
         next_sel_cntl = pins.access_control_field;
         next_sel_rnw  = pins.read_not_write;
         next_sel_half = halfword_bus_mode ? pins.halfword_select : 1'b0;
      end
      case (state)
         HPAP_IDLE: begin
            if (stb_fall) begin
               next_ready_n = 1'b1;
               if (next_sel_rnw) begin
                  next_doe = 1'b1;
                  if ((next_sel_cntl == CNTL_DATA || next_sel_cntl == CNTL_DATA_INC) &&
                      !(halfword_bus_mode && next_sel_half)) begin
                     fetch_req  = 1'b1;
                     next_state = HPAP_FETCH;
                  end else begin
                     next_dout  = (halfword_bus_mode && next_sel_half) ?
                                  {{HALF_W{1'b0}}, rd_word[DATA_W-1:HALF_W]} : rd_word;
                     next_state = HPAP_READY;
                  end
               end else begin
                  next_state = HPAP_WRITE;
               end
            end
         end
         HPAP_FETCH: begin
            if (fetch_valid) begin
               next_rd_word = fetch_data;
               next_dout    = halfword_bus_mode ? {{HALF_W{1'b0}}, fetch_data[HALF_W-1:0]} : fetch_data;
               next_state   = HPAP_READY;  // Ready held high until data loaded
            end
         end
         HPAP_WRITE: begin
            // Full buffer keeps ready high, except on the first half-word of a data write in half-word mode
            if (!halfword_bus_mode || second_half || !is_data) begin
               if (fifo_in_ready) begin
                  next_ready_n = 1'b0;
                  next_state   = HPAP_DONE;
               end
            end else begin
               next_ready_n = 1'b0;
               next_state   = HPAP_DONE;
            end
         end
         HPAP_READY: begin
            next_ready_n = 1'b0;
            next_state   = HPAP_DONE;
         end
         HPAP_DONE: begin
            if (stb_rise) begin
               // Data captured at strobe release
               if (!sel_rnw) begin
                  if (halfword_bus_mode && !second_half && is_data) begin
                     next_wr_low = pins.port_data_bus[HALF_W-1:0];
                  end else begin
                     fifo_in_valid = 1'b1;
                  end
               end
               next_doe   = 1'b0;  // Bus released after strobe rises
               next_state = HPAP_IDLE;
            end
         end
         default: begin
            next_state = HPAP_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state    <= HPAP_IDLE;
         stb_low  <= 1'b0;
         as_low   <= 1'b0;
         sel_cntl <= CNTL_CTRL;
         sel_rnw  <= 1'b0;
         sel_half <= 1'b0;
         rd_word  <= '0;
         wr_low   <= '0;
         ready_n  <= 1'b1;
         dout     <= '0;
         doe      <= 1'b0;
      end else begin
         state    <= next_state;
         stb_low  <= next_stb_low;
         as_low   <= next_as_low;
         sel_cntl <= next_sel_cntl;
         sel_rnw  <= next_sel_rnw;
         sel_half <= next_sel_half;
         rd_word  <= next_rd_word;
         wr_low   <= next_wr_low;
         ready_n  <= next_ready_n;
         dout     <= next_dout;
         doe      <= next_doe;
      end
   end

   assign pins.host_ready_n = ready_n;
   assign pins.dev_data_out = dout;
   assign pins.dev_data_oe  = doe;
endmodule
`default_nettype wire

// [hw/hpap_fifo.sv]
/*
 Flop-based synchronous FIFO with valid/ready on both sides.
 Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module hpap_fifo
   import hpap_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   // Full and empty from the fill count
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule
`default_nettype wire

// [hw/hpap_host.sv]
/*
 Host end of the parallel access port: turns a user request into one strobe
 cycle, or two half-word cycles in half-word mode.
 Assumes the device shares mclk, so ready is a same-clock input and needs no
 synchroniser.
*/
`timescale 1ns/10ps
`default_nettype none
module hpap_host
   import hpap_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   hpap_if.host                   pins,
   input  wire logic              halfword_bus_mode,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_rnw,
   input  wire logic [CNTL_W-1:0] req_cntl,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_rdata
);
   hpap_host_state_t   state;
   hpap_host_state_t   next_state;
   logic [CNT_W-1:0]   cnt;
   logic [CNT_W-1:0]   next_cnt;
   logic               half;
   logic               next_half;
   logic               rnw;
   logic               next_rnw;
   logic [CNTL_W-1:0]  cntl;
   logic [CNTL_W-1:0]  next_cntl;
   logic [DATA_W-1:0]  wdata;
   logic [DATA_W-1:0]  next_wdata;
   logic [DATA_W-1:0]  rdata;
   logic [DATA_W-1:0]  next_rdata;
   logic               rsp;
   logic               next_rsp;
   logic               busy_seen;
   logic               next_busy_seen;
   logic               rdy_low;

   assign req_ready = (state == HPAP_H_IDLE);

   // Ready low left over from the last access must not end this strobe:
   // it counts only after the device has gone busy for this strobe
   always_comb begin
      next_busy_seen = busy_seen;
      if (state == HPAP_H_IDLE || state == HPAP_H_GAP) begin
         next_busy_seen = 1'b0;
      end else if (pins.host_ready_n) begin
         next_busy_seen = 1'b1;
      end
   end
   assign rdy_low = busy_seen & ~pins.host_ready_n;

   // Strobe cycle sequencing
   always_comb begin
      next_state = state;
      next_cnt   = (cnt != CNT_ZERO) ? cnt - CNT_ONE : CNT_ZERO;
      next_half  = half;
      next_rnw   = rnw;
      next_cntl  = cntl;
      next_wdata = wdata;
      next_rdata = rdata;
      next_rsp   = 1'b0;
      case (state)
         HPAP_H_IDLE: begin
            if (req_valid) begin
               next_rnw   = req_rnw;
               next_cntl  = req_cntl;
               next_wdata = req_wdata;
               next_half  = 1'b0;
               next_cnt   = CNT_W'(STROBE_LOW_CYC);
               next_state = HPAP_H_LOW;
            end
         end
         HPAP_H_LOW: begin
            if (cnt == CNT_ZERO) begin
               next_state = HPAP_H_WAIT;
            end
         end
         HPAP_H_WAIT: begin
            // Strobe kept low until ready is low
            if (rdy_low) begin
               if (rnw) begin
                  if (halfword_bus_mode && half) begin
                     next_rdata[DATA_W-1:HALF_W] = pins.port_data_bus[HALF_W-1:0];
                  end else if (halfword_bus_mode) begin
                     next_rdata[HALF_W-1:0] = pins.port_data_bus[HALF_W-1:0];
                  end else begin
                     next_rdata = pins.port_data_bus;
                  end
               end
               next_cnt   = CNT_W'(STROBE_HIGH_CYC);
               next_state = HPAP_H_GAP;
            end
         end
         HPAP_H_GAP: begin
            if (cnt == CNT_ZERO) begin
               if (halfword_bus_mode && !half) begin
                  next_half  = 1'b1;  // Second half-word
                  next_cnt   = CNT_W'(STROBE_LOW_CYC);
                  next_state = HPAP_H_LOW;
               end else begin
                  next_rsp   = 1'b1;
                  next_state = HPAP_H_IDLE;
               end
            end
         end
         default: begin
            next_state = HPAP_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state    <= HPAP_H_IDLE;
         cnt      <= CNT_ZERO;
         half     <= 1'b0;
         rnw      <= 1'b0;
         cntl     <= CNTL_CTRL;
         wdata    <= '0;
         rdata    <= '0;
         rsp      <= 1'b0;
         busy_seen <= 1'b0;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         half     <= next_half;
         rnw      <= next_rnw;
         cntl     <= next_cntl;
         wdata    <= next_wdata;
         rdata    <= next_rdata;
         rsp      <= next_rsp;
         busy_seen <= next_busy_seen;
      end
   end

   // Pins: only data strobe one toggles; address strobe used in half-word mode
   assign pins.port_chip_select_n   = 1'b0;
   assign pins.data_strobe_two_n    = 1'b1;
   assign pins.data_strobe_one_n    = ~(state == HPAP_H_LOW || state == HPAP_H_WAIT);
   assign pins.address_strobe_n     = ~(halfword_bus_mode && state == HPAP_H_LOW);  // One pulse per strobe in half-word mode, none in full-word mode
   assign pins.access_control_field = cntl;  // Selects held through the cycle
   assign pins.read_not_write       = rnw;
   assign pins.halfword_select      = half;
   assign pins.host_data_oe         = ~rnw & (state != HPAP_H_IDLE);
   assign pins.host_data_out        = (halfword_bus_mode && half) ? {{HALF_W{1'b0}}, wdata[DATA_W-1:HALF_W]} :
                                      (halfword_bus_mode ? {{HALF_W{1'b0}}, wdata[HALF_W-1:0]} : wdata);
   assign rsp_valid = rsp;
   assign rsp_rdata = rdata;
endmodule
`default_nettype wire

// [hw/hpap_if.sv]
/*
 Pin bundle between the host and the device end of the parallel access port.
 The shared data bus is resolved here from the two output enables.
*/
`timescale 1ns/10ps
`default_nettype none
interface hpap_if;
   import hpap_pkg::*;
   logic                port_chip_select_n;
   logic                data_strobe_one_n;
   logic                data_strobe_two_n;
   logic                address_strobe_n;
   logic [CNTL_W-1:0]   access_control_field;
   logic                read_not_write;
   logic                halfword_select;
   logic                host_ready_n;
   logic [DATA_W-1:0]   host_data_out;
   logic                host_data_oe;
   logic [DATA_W-1:0]   dev_data_out;
   logic                dev_data_oe;
   wire  [DATA_W-1:0]   port_data_bus;

   // Bus level from whichever end drives it
   assign port_data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : '0);

   modport device (
      input  port_chip_select_n, data_strobe_one_n, data_strobe_two_n, address_strobe_n,
      input  access_control_field, read_not_write, halfword_select, port_data_bus,
      output host_ready_n, dev_data_out, dev_data_oe
   );
   modport host (
      output port_chip_select_n, data_strobe_one_n, data_strobe_two_n, address_strobe_n,
      output access_control_field, read_not_write, halfword_select, host_data_out, host_data_oe,
      input  host_ready_n, port_data_bus
   );
endinterface
`default_nettype wire

// [hw/hpap_pkg.sv]
/*
 Package for the host parallel access port: pin widths, access control codes,
 timing constants and the shared state enumerations.
 Assumes a single 25 MHz system clock shared by both ends.
*/
package hpap_pkg;
   // Clock and timing
   localparam int          CLK_PERIOD_PS      = 40000;
   localparam int          STROBE_MIN_PERIODS = 4;
   localparam int          STROBE_MIN_PS      = 12500;
   localparam int          STROBE_LOW_PS      = (STROBE_MIN_PERIODS * CLK_PERIOD_PS > STROBE_MIN_PS) ?
                                                STROBE_MIN_PERIODS * CLK_PERIOD_PS : STROBE_MIN_PS;
   // Least times round up to whole cycles
   localparam int          STROBE_LOW_CYC     = (STROBE_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          STROBE_HIGH_CYC    = STROBE_MIN_PERIODS;
   // Widths
   localparam int          DATA_W             = 32;
   localparam int          HALF_W             = 16;
   localparam int          CNTL_W             = 2;
   localparam int          CNT_W              = 4;
   localparam int          FIFO_DEPTH         = 16;
   // Access control codes
   localparam logic [1:0]  CNTL_CTRL          = 2'h0;
   localparam logic [1:0]  CNTL_ADDR          = 2'h1;
   localparam logic [1:0]  CNTL_DATA_INC      = 2'h2;
   localparam logic [1:0]  CNTL_DATA          = 2'h3;
   localparam logic [CNT_W-1:0] CNT_ZERO      = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE       = 4'h1;

   // Device-end access states
   typedef enum logic [4:0] {
      HPAP_IDLE  = 5'h01,
      HPAP_FETCH = 5'h02,
      HPAP_WRITE = 5'h04,
      HPAP_READY = 5'h08,
      HPAP_DONE  = 5'h10
   } hpap_dev_state_t;

   // Host-end access states
   typedef enum logic [4:0] {
      HPAP_H_IDLE = 5'h01,
      HPAP_H_LOW  = 5'h02,
      HPAP_H_WAIT = 5'h04,
      HPAP_H_REL  = 5'h08,
      HPAP_H_GAP  = 5'h10
   } hpap_host_state_t;

   // Active-low combined strobe from chip select and two data strobes
   function automatic logic hpap_strobe(input logic cs_n, input logic ds1_n, input logic ds2_n);
      return ~(ds1_n ^ ds2_n) | cs_n;
   endfunction
endpackage
